// file: gepol_cfg.svh
// constants for the gpio event edge polarity block
// assumes inclusion from gepol_pkg and the design modules
`ifndef GEPOL_CFG_SVH
`define GEPOL_CFG_SVH
`define GEPOL_NPINS 16
`define GEPOL_ADDR_W 8
`define GEPOL_OFF_POL 8'h00
`define GEPOL_OFF_GCTL 8'h04
`define GEPOL_OFF_STAT 8'h08
`define GEPOL_OFF_MASK 8'h0C
`define GEPOL_OFF_VAL 8'h10
`define GEPOL_GCTL_MODE_BIT 4
`define GEPOL_POL_RST 16'h0000
`define GEPOL_GCTL_RST 32'h00000000
`define GEPOL_MASK_RST 16'h0000
`endif

// file: gepol_edge.sv
// per-pin edge detector with selectable polarity
// assumes pins are already synchronous to clk
module gepol_edge
    import gepol_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic pin,
    input wire logic falling,
    output logic edge_pulse
);
    logic prev_r;

    // previous sampled pin value
    always_ff @(posedge clk)
    begin
        if (reset)
            prev_r <= 1'b0;
        else
            prev_r <= pin;
    end

    // rising when polarity 0, falling when polarity 1
    always_comb
    begin
        if (falling)
            edge_pulse = prev_r & ~pin;
        else
            edge_pulse = ~prev_r & pin;
    end

    // a one-clock pulse only after the selected transition
    property p_pulse_cause;
        @(posedge clk) disable iff (reset)
        edge_pulse && !$past(reset) |->
            ($past(pin) != pin) && (pin == ~falling);
    endproperty
    a_pulse_cause: assert property (p_pulse_cause)
        else $error("edge pulse without matching transition");
endmodule

// file: gepol_pins.sv
// pin levels and logic-mode event source at the block's far side
// assumes the bench sets new targets on the rising clock edge
module gepol_pins
    import gepol_pkg::*;
(
    input wire logic clk,
    input wire gepol_vec_t pin_set,
    input wire logic logic_set,
    output gepol_vec_t io_pin_n,
    output logic combined_logic_event
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins and logic event settle one clock after a new target
    initial
    begin
        io_pin_n = '0;
        combined_logic_event = 1'b0;
    end
    always @(posedge clk)
    begin
        io_pin_n <= pin_set;
        combined_logic_event <= logic_set;
    end
endmodule

// file: gepol_pkg.sv
// types for the gpio event edge polarity block
// assumes gepol_cfg.svh is on the include path
package gepol_pkg;
`include "gepol_cfg.svh"
    typedef logic [`GEPOL_NPINS-1:0] gepol_vec_t;
    typedef enum logic [0:0]
    {
        GEPOL_PASS = 1'b0,
        GEPOL_LOGIC = 1'b1
    } gepol_mode_t;
endpackage

// file: gepol_top.sv
// gpio event edge polarity: registers, edge events, interrupt
// assumes a plain strobe register port and synchronous pin inputs
// Function
// - sixteen polarity bits, one per pin event, at bits 15 to 0
// - polarity 0: event pulses high on pin rising edge
// - polarity 1: event pulses high on pin falling edge
// - polarity bit 0 only matters while event 0 mode select is 0
// - polarity bits 31 to 16 read zero, writes ignored
// - polarity applies to pass-through events only
// - mode bit 4: 0 pin 0 edge, 1 combined logic event
`include "gepol_cfg.svh"
module gepol_top
    import gepol_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [`GEPOL_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [`GEPOL_NPINS-1:0] io_pin_n,
    input wire logic combined_logic_event,
    output logic [`GEPOL_NPINS-1:0] pin_event_out,
    output logic irq
);
    // ***************************************************
    // registers
    // ***************************************************
    gepol_vec_t event_edge_polarity_r;
    logic [31:0] global_event_control_r;
    gepol_vec_t status_r;
    gepol_vec_t mask_r;
    gepol_vec_t edges;
    gepol_vec_t ev_nxt;
    gepol_mode_t mode;
    logic [31:0] rdata_nxt;

    assign mode = gepol_mode_t'(
        global_event_control_r[`GEPOL_GCTL_MODE_BIT]);

    // polarity register, upper half dropped
    always_ff @(posedge clk)
    begin
        if (reset)
            event_edge_polarity_r <= `GEPOL_POL_RST;
        else if (wr && addr == `GEPOL_OFF_POL)
            event_edge_polarity_r <= wdata[15:0];
    end

    // global control, only the mode bit is held
    always_ff @(posedge clk)
    begin
        if (reset)
            global_event_control_r <= `GEPOL_GCTL_RST;
        else if (wr && addr == `GEPOL_OFF_GCTL)
            global_event_control_r <=
                {27'h0000000, wdata[`GEPOL_GCTL_MODE_BIT], 4'h0};
    end

    // interrupt mask
    always_ff @(posedge clk)
    begin
        if (reset)
            mask_r <= `GEPOL_MASK_RST;
        else if (wr && addr == `GEPOL_OFF_MASK)
            mask_r <= wdata[15:0];
    end

    // ***************************************************
    // edge detection
    // ***************************************************
    genvar g;
    generate
        for (g = 0; g < `GEPOL_NPINS; g++)
        begin : g_pin
            gepol_edge u_edge
            (
                .clk(clk),
                .reset(reset),
                .pin(io_pin_n[g]),
                .falling(event_edge_polarity_r[g]),
                .edge_pulse(edges[g])
            );
        end
    endgenerate

    // event 0 source chosen by mode select
    always_comb
    begin
        ev_nxt = edges;
        if (mode == GEPOL_LOGIC)
            ev_nxt[0] = combined_logic_event;
    end

    // registered event outputs
    always_ff @(posedge clk)
    begin
        if (reset)
            pin_event_out <= '0;
        else
            pin_event_out <= ev_nxt;
    end

    // ***************************************************
    // interrupt status
    // ***************************************************
    // sticky, write one clears, set wins
    always_ff @(posedge clk)
    begin
        if (reset)
            status_r <= '0;
        else if (wr && addr == `GEPOL_OFF_STAT)
            status_r <= (status_r & ~wdata[15:0]) | pin_event_out;
        else
            status_r <= status_r | pin_event_out;
    end

    assign irq = |(status_r & mask_r);

    // ***************************************************
    // read port
    // ***************************************************
    always_comb
    begin
        rdata_nxt = 32'h00000000;
        case (addr)
            `GEPOL_OFF_POL: rdata_nxt = {16'h0000,
                event_edge_polarity_r};
            `GEPOL_OFF_GCTL: rdata_nxt = global_event_control_r;
            `GEPOL_OFF_STAT: rdata_nxt = {16'h0000, status_r};
            `GEPOL_OFF_MASK: rdata_nxt = {16'h0000, mask_r};
            `GEPOL_OFF_VAL: rdata_nxt = {16'h0000, io_pin_n};
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    // read data valid the cycle after the strobe only
    always_ff @(posedge clk)
    begin
        if (reset)
            rdata <= 32'h00000000;
        else if (rd)
            rdata <= rdata_nxt;
        else
            rdata <= 32'h00000000;
    end

    // ***************************************************
    // checks
    // ***************************************************
    property p_rising;
        @(posedge clk) disable iff (reset)
        (event_edge_polarity_r[1] == 1'b0) && $rose(io_pin_n[1])
            |=> pin_event_out[1];
    endproperty
    a_rising: assert property (p_rising)
        else $error("missing rising edge event");

    property p_falling;
        @(posedge clk) disable iff (reset)
        (event_edge_polarity_r[1] == 1'b1) && $fell(io_pin_n[1])
            |=> pin_event_out[1];
    endproperty
    a_falling: assert property (p_falling)
        else $error("missing falling edge event");

    property p_logic_ev0;
        @(posedge clk) disable iff (reset)
        mode == GEPOL_LOGIC |=> pin_event_out[0] ==
            $past(combined_logic_event);
    endproperty
    a_logic_ev0: assert property (p_logic_ev0)
        else $error("event 0 not from logic event in logic mode");

    property p_upper_zero;
        @(posedge clk) disable iff (reset)
        rd && addr == `GEPOL_OFF_POL |=> rdata[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("polarity upper bits read nonzero");

    property p_pol_write;
        @(posedge clk) disable iff (reset)
        wr && addr == `GEPOL_OFF_POL |=>
            event_edge_polarity_r == $past(wdata[15:0]);
    endproperty
    a_pol_write: assert property (p_pol_write)
        else $error("polarity write not stored");

    property p_one_clock;
        @(posedge clk) disable iff (reset)
        pin_event_out[2] |=> !pin_event_out[2];
    endproperty
    a_one_clock: assert property (p_one_clock)
        else $error("pin event longer than one clock");

    property p_no_edge_no_event;
        @(posedge clk) disable iff (reset)
        ##1 $stable(io_pin_n[3]) |=> !pin_event_out[3];
    endproperty
    a_no_edge_no_event: assert property (p_no_edge_no_event)
        else $error("event without pin transition");

    property p_sticky;
        @(posedge clk) disable iff (reset)
        pin_event_out[5] |=> status_r[5];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("status bit not set by event");

    // write one clears a status bit when no event sets it
    property p_clear;
        @(posedge clk) disable iff (reset)
        wr && addr == `GEPOL_OFF_STAT && wdata[6] && !pin_event_out[6]
            |=> !status_r[6];
    endproperty
    a_clear: assert property (p_clear)
        else $error("status bit not cleared by write one");

    // read data zero outside the cycle after a read
    property p_idle_rdata;
        @(posedge clk) disable iff (reset)
        !rd |=> rdata == 32'h00000000;
    endproperty
    a_idle_rdata: assert property (p_idle_rdata)
        else $error("read data outside the read cycle");
endmodule

// file: testbench.sv
// self-checking bench for the edge polarity block
// assumes gepol_pkg compiled first and the pin model beside it
module testbench
    import gepol_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
        n_errors++; $display("mismatch at %0t got %0h exp %0h", \
        $time, a, b); end end
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic logic_set = 1'b0;
    logic irq;
    logic combined_logic_event;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata;
    gepol_vec_t pin_set = '0;
    gepol_vec_t pol = '0;
    gepol_vec_t io_pin_n;
    gepol_vec_t pin_event_out;
    int n_errors = 0;
    int n_compared = 0;
    // ************************************************
    // clock, dut and pin model
    // ************************************************
    initial
    begin
        forever #2 clk = ~clk;
    end
    gepol_top gepol_top_inst (.clk(clk), .reset(reset), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .io_pin_n(io_pin_n), .combined_logic_event(combined_logic_event),
        .pin_event_out(pin_event_out), .irq(irq));
    gepol_pins gepol_pins_inst (.clk(clk), .pin_set(pin_set),
        .logic_set(logic_set), .io_pin_n(io_pin_n),
        .combined_logic_event(combined_logic_event));
    // ************************************************
    // bus and event tasks
    // ************************************************
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK(rdata, exp)
    endtask
    // expected events: rising where polarity 0, falling where 1
    task ev_chk(input gepol_vec_t nxt, input gepol_vec_t msk);
        gepol_vec_t ev;
        gepol_vec_t exp;
        int hits;
        exp = ((nxt & ~pin_set & ~pol) | (pin_set & ~nxt & pol)) & msk;
        ev = '0;
        hits = 0;
        @(posedge clk);
        pin_set <= nxt;
        repeat (6)
        begin
            @(negedge clk);
            ev = ev | pin_event_out;
            if (pin_event_out !== '0)
                hits++;
        end
        `CHK(ev, exp)
        `CHK(hits, int'(exp != '0))
    endtask
    // ************************************************
    // scenarios
    // ************************************************
    task t_regs;
        rd_chk(8'h00, 32'h00000000);
        wr_reg(8'h00, 32'hFFFF5A5A);
        pol = 16'h5A5A;
        rd_chk(8'h00, 32'h00005A5A);
        rd_chk(8'h20, 32'h00000000);
        $display("regs done");
    endtask
    task t_edges;
        ev_chk(16'hFFFF, '1);
        ev_chk(16'h0000, '1);
        ev_chk(16'h00FF, '1);
        $display("edges done");
    endtask
    task t_mode;
        wr_reg(8'h04, 32'hFFFFFFFF);
        rd_chk(8'h04, 32'h00000010);
        ev_chk(pin_set ^ 16'h0001, 16'hFFFE);
        ev_chk(pin_set ^ 16'h0001, 16'hFFFE);
        @(posedge clk);
        logic_set <= 1'b1;
        repeat (3) @(negedge clk);
        `CHK(pin_event_out[0], 1'b1)
        @(posedge clk);
        logic_set <= 1'b0;
        repeat (3) @(negedge clk);
        `CHK(pin_event_out[0], 1'b0)
        wr_reg(8'h04, 32'h00000000);
        ev_chk(pin_set ^ 16'h0001, '1);
        ev_chk(pin_set ^ 16'h0001, '1);
        $display("mode done");
    endtask
    task t_irq;
        wr_reg(8'h00, 32'h00000000);
        pol = '0;
        ev_chk(16'h0000, '1);
        wr_reg(8'h08, 32'h0000FFFF);
        ev_chk(16'h0001, '1);
        rd_chk(8'h08, 32'h00000001);
        rd_chk(8'h10, 32'h00000001);
        `CHK(irq, 1'b0)
        wr_reg(8'h0C, 32'h00000001);
        #1 `CHK(irq, 1'b1)
        wr_reg(8'h08, 32'h00000001);
        #1 `CHK(irq, 1'b0)
        $display("irq done");
    endtask
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // main sequence after 20 reset cycles
    initial
    begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_edges();
        t_mode();
        t_irq();
        summarize();
    end
    // watchdog
    initial
    begin
        #20000;
        n_errors++;
        summarize();
    end
endmodule
